// ==== hdl/tmr_params.svh ====
// constants for the timer0 block with shared prescaler
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

`define TMR_COUNT_ADDR 8'h01
`define TMR_CFG_RESET 6'h3F
`define TMR_CFG_CS_BIT 5
`define TMR_CFG_SE_BIT 4
`define TMR_CFG_ASSIGN_BIT 3
`define TMR_CFG_PS_MSB 2
`define TMR_CFG_PS_LSB 0
`define TMR_PRESC_RESET 8'h00
`define TMR_COUNT_RESET 8'h00
`define TMR_COUNT_MAX 8'hFF
`define TMR_INHIBIT_CYCLES 2'h2
`define TMR_INHIBIT_ZERO 2'h0
`define TMR_INHIBIT_STEP 2'h1

`endif

// ==== hdl/tmr_pkg.sv ====
// shared types for the timer0 block
package tmr_pkg;
  typedef enum logic [1:0] {TMR_PHASE_ONE, TMR_PHASE_TWO, TMR_PHASE_THREE, TMR_PHASE_FOUR} tmr_phase_e;
  typedef logic [7:0] tmr_byte_t;
endpackage

// ==== hdl/tmr_sync_edge.sv ====
// two-stage pin synchroniser with polarity select and rising-edge detect
`timescale 1ns/1ps
module tmr_sync_edge (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_invert,
  output logic o_level,
  output logic o_rise
);
  logic meta;
  logic stable;
  logic stable_d;
  logic pol_level;

  // polarity applied after the second stage only
  assign pol_level = stable ^ i_invert;
  assign o_level = pol_level;
  // delay kept raw so a polarity change makes no false edge
  assign o_rise = pol_level & ~(stable_d ^ i_invert);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta <= i_pin;
      stable <= meta;
      stable_d <= stable;
    end
  end
endmodule

// ==== hdl/tmr_timer0.sv ====
// timer0 counter with shared 8-bit prescaler and watchdog routing
//
// How it works
// RL1 - source 0: count instruction cycles, maybe prescaled
// RL2 - count write blocks counting two instruction cycles
// RL3 - source 1: count external input edges
// RL4 - edge select 0 rising, 1 falling
// RL5 - prescaler goes to timer or watchdog only
// RL6 - timer ratios 1:2 up to 1:256
// RL7 - prescaler hidden from software reads and writes
// RL8 - count write clears prescaler when timer owns it
// RL9 - watchdog clear zeroes prescaler when watchdog owns
// RL10 - reset loads prescaler with zeros
// RL11 - count register readable writable at 01h
// RL12 - sample source on phase two and four
// RL13 - external input divided before phase sampling
// RL14 - unprescaled input high and low two periods
// RL15 - prescaled input period four periods over ratio
// RL16 - increment three to seven periods after edge
// RL17 - software sequence for timer to watchdog switch
// RL18 - software sequence for watchdog to timer switch
// RL19 - that switch: watchdog clear then config write
// RL20 - ratio is two to ratio plus one
// RL21 - count wraps from FF to 00
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_timer0 (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_count_wr,
  input wire logic [7:0] i_count_addr,
  input wire logic [7:0] i_count_wdata,
  input wire logic i_cfg_wr,
  input wire logic [5:0] i_cfg_wdata,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_watchdog_tick,
  input wire logic i_ext_count_input,
  output logic [7:0] o_timer_count_reg,
  output logic o_watchdog_prescaled_tick,
  output logic o_instr_cycle,
  output logic o_prescaler_assign
);
  tmr_pkg::tmr_phase_e phase;
  tmr_pkg::tmr_phase_e next_phase;
  tmr_pkg::tmr_byte_t timer_count_reg;
  tmr_pkg::tmr_byte_t prescaler;
  logic [5:0] cfg;
  logic [1:0] inhibit_cnt;
  logic presc_out_d;
  logic samp_level;
  logic samp_level_d;
  logic watchdog_tick_q;

  wire count_source_select = cfg[`TMR_CFG_CS_BIT];
  wire source_edge_select = cfg[`TMR_CFG_SE_BIT];
  wire prescaler_assign = cfg[`TMR_CFG_ASSIGN_BIT];
  wire [2:0] prescale_ratio_bits = cfg[`TMR_CFG_PS_MSB:`TMR_CFG_PS_LSB];
  wire ext_level;
  wire ext_rise;

  // RL4 edge select
  tmr_sync_edge u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_count_input),
    .i_invert(source_edge_select),
    .o_level(ext_level),
    .o_rise(ext_rise)
  );

  always_comb begin
    case (phase)
      tmr_pkg::TMR_PHASE_ONE: next_phase = tmr_pkg::TMR_PHASE_TWO;
      tmr_pkg::TMR_PHASE_TWO: next_phase = tmr_pkg::TMR_PHASE_THREE;
      tmr_pkg::TMR_PHASE_THREE: next_phase = tmr_pkg::TMR_PHASE_FOUR;
      tmr_pkg::TMR_PHASE_FOUR: next_phase = tmr_pkg::TMR_PHASE_ONE;
      default: next_phase = tmr_pkg::TMR_PHASE_ONE;
    endcase
  end

  wire instr_end = (phase == tmr_pkg::TMR_PHASE_FOUR);
  wire phase_sample = (phase == tmr_pkg::TMR_PHASE_TWO) || (phase == tmr_pkg::TMR_PHASE_FOUR);
  wire count_hit = i_count_wr && (i_count_addr == `TMR_COUNT_ADDR);
  wire timer_owns = ~prescaler_assign;

  // RL3 source mux
  wire src_event = count_source_select ? ext_rise : instr_end;
  // RL5 RL13 prescaler input routing
  // divider counts synchronised edges, so no ripple stage is needed
  wire presc_event = timer_owns ? src_event : i_watchdog_tick;
  // RL8 RL9 prescaler clears
  wire presc_clear = (count_hit && timer_owns) ||
                     (i_watchdog_clear_instr && prescaler_assign);
  // RL6 RL20 bit n toggles every 2^n events: ratio 2^(n+1), symmetric
  wire presc_out = prescaler[prescale_ratio_bits];
  wire presc_rise = presc_out & ~presc_out_d;

  // RL12 RL16 raw level sampled on phase two and four
  // raw level kept so reset or an edge-select change makes no false count
  wire samp_invert = timer_owns ? 1'b0 : source_edge_select;
  wire samp_source = timer_owns ? presc_out : (ext_level ^ source_edge_select);
  wire samp_rise = (samp_level ^ samp_invert) & ~(samp_level_d ^ samp_invert);

  // RL1 RL3 increment source select
  // internal prescaled clock needs no phase sampling, it is already synchronous
  wire inc_event = count_source_select ? samp_rise :
                   (timer_owns ? presc_rise : instr_end);
  // RL2 increment gate
  wire inc = inc_event && (inhibit_cnt == `TMR_INHIBIT_ZERO) && !count_hit;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= tmr_pkg::TMR_PHASE_ONE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= `TMR_CFG_RESET;
    end else if (i_cfg_wr) begin
      cfg <= i_cfg_wdata;
    end
  end

  // RL7 RL10 prescaler only cleared or counted, never loaded
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescaler <= `TMR_PRESC_RESET;
    end else if (presc_clear) begin
      prescaler <= `TMR_PRESC_RESET;
    end else if (presc_event) begin
      prescaler <= prescaler + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_out_d <= 1'b0;
      samp_level <= 1'b0;
      samp_level_d <= 1'b0;
      watchdog_tick_q <= 1'b0;
    end else begin
      presc_out_d <= presc_out;
      samp_level_d <= samp_level;
      if (phase_sample) begin
        samp_level <= samp_source;
      end
      // RL5 watchdog sees ticks only while it owns the prescaler
      watchdog_tick_q <= prescaler_assign & presc_rise;
    end
  end

  // RL2 two instruction cycle hold-off
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      inhibit_cnt <= `TMR_INHIBIT_ZERO;
    end else if (count_hit) begin
      inhibit_cnt <= `TMR_INHIBIT_CYCLES;
    end else if (instr_end && inhibit_cnt != `TMR_INHIBIT_ZERO) begin
      inhibit_cnt <= inhibit_cnt - `TMR_INHIBIT_STEP;
    end
  end

  // RL11 RL21 count register, write beats increment
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_count_reg <= `TMR_COUNT_RESET;
    end else if (count_hit) begin
      timer_count_reg <= i_count_wdata;
    end else if (inc) begin
      timer_count_reg <= timer_count_reg + 8'h01;
    end
  end

  assign o_timer_count_reg = timer_count_reg;
  assign o_watchdog_prescaled_tick = watchdog_tick_q;
  assign o_instr_cycle = instr_end;
  assign o_prescaler_assign = prescaler_assign;

  // checks
  property p_wrap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    inc && (timer_count_reg == `TMR_COUNT_MAX) |=> timer_count_reg == `TMR_COUNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap"); // RL21

  property p_write_loads;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    count_hit |=> timer_count_reg == $past(i_count_wdata);
  endproperty
  a_write_loads: assert property (p_write_loads) else $error("write not stored"); // RL11

  sequence s_write;
    count_hit ##1 !count_hit;
  endsequence
  property p_inhibit;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_write |-> (!inc) [*5];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("count moved during hold-off"); // RL2

  property p_timer_rate;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !count_source_select && prescaler_assign && instr_end && !count_hit &&
    inhibit_cnt == `TMR_INHIBIT_ZERO |=> timer_count_reg == $past(timer_count_reg) + 8'h01;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("no instruction increment"); // RL1

  property p_clr_timer;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    count_hit && timer_owns |=> prescaler == `TMR_PRESC_RESET;
  endproperty
  a_clr_timer: assert property (p_clr_timer) else $error("prescaler kept on write"); // RL8

  property p_clr_watchdog;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_watchdog_clear_instr && prescaler_assign |=> prescaler == `TMR_PRESC_RESET;
  endproperty
  a_clr_watchdog: assert property (p_clr_watchdog) else $error("prescaler kept on clear"); // RL9

  property p_exclusive;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    timer_owns && $past(timer_owns) |-> !o_watchdog_prescaled_tick;
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("watchdog tick while timer owns"); // RL5

  sequence s_ext_edge;
    count_source_select && prescaler_assign && ext_rise && !count_hit &&
    inhibit_cnt == `TMR_INHIBIT_ZERO && !i_cfg_wr;
  endsequence
  property p_ext_latency;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_ext_edge |-> ##[1:2] (inc || count_hit || i_cfg_wr);
  endproperty
  a_ext_latency: assert property (p_ext_latency) else $error("external edge not counted"); // RL16
endmodule

// ==== verif/tmr_ext_src.sv ====
// count pin source model
`timescale 1ns/1ps
module tmr_ext_src (
  input wire logic i_go,
  input wire logic [7:0] i_pulses,
  input wire logic [15:0] i_half_ns,
  output logic o_pin,
  output logic o_done
);
  initial begin
    o_pin = 1'b0;
    o_done = 1'b0;
  end
  always @(posedge i_go) begin
    o_done = 1'b0;
    repeat (i_pulses) begin
      o_pin = 1'b1;
      #(i_half_ns);
      o_pin = 1'b0;
      #(i_half_ns);
    end
    o_done = 1'b1;
  end
endmodule

// ==== verif/tmr_timer0_test.sv ====
// self-checking bench for the timer0 block
`timescale 1ns/1ps
module tmr_timer0_test;
  logic i_clk_sys, i_rst_n, cwr, fwr, wclr, wtk, go, pin, done, wdo, ic, pown;
  logic [7:0] ca, cd, cnt, npul, k;
  logic [5:0] fd;
  logic [15:0] half;
  int err_count = 0, checks = 0, wc = 0, w0;
  tmr_timer0 tmr_timer0_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_count_wr(cwr),
    .i_count_addr(ca), .i_count_wdata(cd), .i_cfg_wr(fwr), .i_cfg_wdata(fd),
    .i_watchdog_clear_instr(wclr), .i_watchdog_tick(wtk), .i_ext_count_input(pin),
    .o_timer_count_reg(cnt), .o_watchdog_prescaled_tick(wdo), .o_instr_cycle(ic),
    .o_prescaler_assign(pown));
  tmr_ext_src tmr_ext_src_i (.i_go(go), .i_pulses(npul), .i_half_ns(half), .o_pin(pin),
    .o_done(done));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (wdo === 1'b1) wc <= wc + 1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic smp;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      while (ic !== 1'b1) @(posedge i_clk_sys);
    end
  endtask
  // s: 0 count write, 1 config, 2 watchdog clear, 3 watchdog tick
  task automatic drv(input int s, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    ca <= a;
    cd <= d;
    fd <= d[5:0];
    cwr <= (s == 0);
    fwr <= (s == 1);
    wclr <= (s == 2);
    wtk <= (s == 3);
    @(posedge i_clk_sys);
    {cwr, fwr, wclr, wtk} <= 4'h0;
  endtask
  // timer to watchdog hand-over; extra clear guards the two fastest ratios
  task automatic sw_wdog(input logic [5:0] f);
    drv(2, 8'h00, 8'h00);
    drv(0, 8'h01, 8'h00);
    drv(1, 8'h00, {2'b00, f[5:4], 4'hF});
    drv(2, 8'h00, 8'h00);
    drv(1, 8'h00, {2'b00, f});
  endtask
  task automatic pls(input logic [15:0] h);
    @(posedge i_clk_sys);
    npul <= 8'h01;
    half <= h;
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
  endtask
  task automatic pend;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(posedge i_clk_sys);
      k++;
    end
    repeat (10) @(posedge i_clk_sys);
    #1;
    chk({7'h00, done}, 8'h01);
  endtask
  task automatic t_free;
    drv(0, 8'h02, 8'h55);
    smp;
    chk(cnt, 8'h00);
    drv(1, 8'h00, 8'h08);
    tick(1);
    drv(0, 8'h01, 8'hFE);
    tick(2);
    smp;
    chk(cnt, 8'hFE);
    tick(2);
    smp;
    chk(cnt, 8'h00);
    $display("free run test done");
  endtask
  task automatic t_ratio;
    logic [7:0] c1;
    drv(2, 8'h00, 8'h00);
    for (int n = 0; n < 8; n++) begin
      drv(1, 8'h00, 8'(n));
      drv(0, 8'h01, 8'h00);
      tick(8);
      smp;
      c1 = cnt;
      tick(2 << (n + 1));
      smp;
      chk(cnt, c1 + 8'h02);
    end
    $display("ratio test done");
  endtask
  task automatic t_edge(input logic se);
    sw_wdog({1'b1, se, 4'h8});
    drv(0, 8'h01, 8'h10);
    tick(3);
    pls(16'd200);
    @(posedge i_clk_sys);
    #1;
    chk(cnt, 8'h10);
    repeat (5) @(posedge i_clk_sys);
    #1;
    chk(cnt, se ? 8'h10 : 8'h11);
    pend;
    chk(cnt, 8'h11);
    $display("edge test %0d done", se);
  endtask
  task automatic t_pre;
    drv(2, 8'h00, 8'h00);
    drv(1, 8'h00, 8'h20);
    drv(0, 8'h01, 8'h10);
    tick(3);
    pls(16'd45);
    pend;
    chk(cnt, 8'h11);
    drv(0, 8'h01, 8'h10);
    tick(3);
    pls(16'd45);
    pend;
    chk(cnt, 8'h11);
    $display("prescaled pin test done");
  endtask
  task automatic t_rst;
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    smp;
    chk({7'h00, pown}, 8'h01);
    drv(1, 8'h00, 8'h39);
    w0 = wc;
    drv(3, 8'h00, 8'h00);
    repeat (3) smp;
    chk(8'(wc - w0), 8'h00);
    $display("reset test done");
  endtask
  task automatic t_watchdog;
    drv(2, 8'h00, 8'h00);
    w0 = wc;
    repeat (17) drv(3, 8'h00, 8'h00);
    repeat (3) smp;
    chk(8'(wc - w0), 8'h04);
    drv(2, 8'h00, 8'h00);
    drv(3, 8'h00, 8'h00);
    repeat (3) smp;
    chk(8'(wc - w0), 8'h04);
    drv(2, 8'h00, 8'h00);
    drv(1, 8'h00, 8'h01);
    repeat (8) drv(3, 8'h00, 8'h00);
    repeat (3) smp;
    chk(8'(wc - w0), 8'h04);
    $display("watchdog test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    {cwr, fwr, wclr, wtk, go, ca, cd, fd, npul, half} = '0;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_free;
    t_ratio;
    t_edge(1'b0);
    t_edge(1'b1);
    t_pre;
    t_rst;
    t_watchdog;
    results;
  end
  // tests need about 5k cycles; allow ample margin
  initial begin
    #300000;
    err_count++;
    results;
  end
endmodule
